// ==== hw/sfdpt_pkg.sv ====
// Constants for the parameter-table tail and unique identifier read.
package sfdpt_pkg;
    localparam logic [7:0] CMD_UID = 8'h5A;
    localparam logic [7:0] CMD_SFDP = 8'h5B;
    localparam logic [4:0] CMD_CNT = 5'h07;
    localparam logic [4:0] ADDR_CNT = 5'h17;
    localparam logic [4:0] DUMMY_CNT = 5'h07;
    localparam logic [23:0] UID_ADDR = 24'h000080;
    localparam logic [7:0] UID_LAST = 8'h8B;
    localparam int UID_BITS = 96;
    localparam logic [95:0] UID_VALUE = 96'h0123456789ABCDEF01234567;
    localparam logic [7:0] TAIL_FIRST = 8'h44;
    localparam logic [7:0] TAIL_LAST = 8'h53;
    localparam logic [7:0] RSVD_BYTE = 8'hFF;
    localparam logic [7:0] ERASED_BYTE = 8'hFF;
    localparam logic [7:0] STATUS_RESET = 8'h00;
    localparam logic [7:0] BYTE_40 = 8'hFE;
    localparam logic [4:0] DDD_WAIT = 5'h00;
    localparam logic [2:0] DDD_MODE = 3'h0;
    localparam logic [7:0] DDD_OPC = 8'hFF;
    localparam logic [4:0] QQQ_WAIT = 5'h04;
    localparam logic [2:0] QQQ_MODE = 3'h2;
    localparam logic [7:0] QQQ_OPC = 8'hEB;
    localparam logic [7:0] ST1_SIZE = 8'h0C;
    localparam logic [7:0] ST1_OPC = 8'h20;
    localparam logic [7:0] ST2_SIZE = 8'h0F;
    localparam logic [7:0] ST2_OPC = 8'h52;
    localparam logic [7:0] ST3_SIZE = 8'h10;
    localparam logic [7:0] ST3_OPC = 8'hD8;
    localparam logic [7:0] ST4_SIZE = 8'h00;
    localparam logic [7:0] ST4_OPC = 8'hFF;
    localparam int PU_TIME_US = 100;
    localparam int CLK_MHZ = 10;
    localparam int PU_CYCLES = PU_TIME_US * CLK_MHZ;
endpackage

// ==== hw/sfdpt_rom.sv ====
// Byte lookup for the parameter-table tail and the unique identifier.
`timescale 1ns/1ps
`default_nettype none
module sfdpt_rom (
    input wire logic [7:0] addr_in,
    input wire logic uid_sel_in,
    output logic [7:0] data_out
);
    wire [3:0] uid_idx = 4'(addr_in - sfdpt_pkg::UID_ADDR[7:0]);
    wire uid_hit = (addr_in >= sfdpt_pkg::UID_ADDR[7:0]) && (addr_in <= sfdpt_pkg::UID_LAST);
    wire [7:0] uid_byte = sfdpt_pkg::UID_VALUE[95 - 8 * uid_idx -: 8];
    logic [7:0] tbl;
    always_comb begin
        tbl = sfdpt_pkg::ERASED_BYTE;
        case (addr_in)
            8'h40: tbl = sfdpt_pkg::BYTE_40 | 8'h10;
            8'h44, 8'h45, 8'h48, 8'h49: tbl = sfdpt_pkg::RSVD_BYTE;
            8'h46: tbl = {sfdpt_pkg::DDD_MODE, sfdpt_pkg::DDD_WAIT};
            8'h47: tbl = sfdpt_pkg::DDD_OPC;
            8'h4A: tbl = {sfdpt_pkg::QQQ_MODE, sfdpt_pkg::QQQ_WAIT};
            8'h4B: tbl = sfdpt_pkg::QQQ_OPC;
            8'h4C: tbl = sfdpt_pkg::ST1_SIZE;
            8'h4D: tbl = sfdpt_pkg::ST1_OPC;
            8'h4E: tbl = sfdpt_pkg::ST2_SIZE;
            8'h4F: tbl = sfdpt_pkg::ST2_OPC;
            8'h50: tbl = sfdpt_pkg::ST3_SIZE;
            8'h51: tbl = sfdpt_pkg::ST3_OPC;
            8'h52: tbl = sfdpt_pkg::ST4_SIZE;
            8'h53: tbl = sfdpt_pkg::ST4_OPC;
            default: tbl = sfdpt_pkg::ERASED_BYTE;
        endcase
    end
    assign data_out = (uid_sel_in && uid_hit) ? uid_byte : (uid_sel_in ? sfdpt_pkg::ERASED_BYTE : tbl);
endmodule
`default_nettype wire

// ==== hw/sfdpt_top.sv ====
// Serial slave answering the identifier read and parameter-table reads.
// How it works
// - Identifier bits shift out, changing on serial clock falling edges.
// - Identifier is fixed at bytes 80h to 8Bh, read-only.
// - Reserved table bytes 44h-45h and 48h-49h read FFh.
// - Dual-dual-dual read reported unsupported: zero waits, opcode FFh.
// - All-quad read reports four dummy clocks and eight mode bits.
// - All-quad opcode EBh; host must enter four-line mode first.
// - Sector type one: size 0Ch, opcode 20h.
// - Sector type two: size 0Fh, opcode 52h.
// - Sector type three: size 10h, opcode D8h.
// - Sector type four unsupported: size 00h, opcode FFh.
// - After delivery array reads FFh, status reads 00h.
// - All-quad support bit reads one.
`timescale 1ns/1ps
`default_nettype none
module sfdpt_top #(
    parameter int PU_CYCLES = sfdpt_pkg::PU_CYCLES
) (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic sck_in,
    input wire logic cs_n_in,
    input wire logic si_in,
    output logic so_out,
    output logic so_oe_n_out,
    output logic ready_out,
    output logic [7:0] status_out
);
    typedef enum logic [4:0] {
        SFDPT_CMD = 5'h01,
        SFDPT_ADDR = 5'h02,
        SFDPT_DUMMY = 5'h04,
        SFDPT_DATA = 5'h08,
        SFDPT_IGNORE = 5'h10
    } sfdpt_state_t;

    logic [2:0] sck_sync_r;
    logic [1:0] cs_sync_r;
    logic [1:0] si_sync_r;
    sfdpt_state_t state_r;
    sfdpt_state_t state_nxt;
    logic [4:0] cnt_r;
    logic [4:0] cnt_nxt;
    logic [7:0] shift_r;
    logic uid_r;
    logic uid_nxt;
    logic [7:0] addr_r;
    logic [7:0] addr_nxt;
    logic [7:0] out_byte_r;
    logic [7:0] out_byte_nxt;
    logic [2:0] bit_r;
    logic [2:0] bit_nxt;
    logic so_r;
    logic so_nxt;
    logic oe_n_r;
    logic oe_n_nxt;
    logic [10:0] pu_cnt_r;
    logic [10:0] pu_cnt_nxt;
    logic ready_r;
    logic ready_nxt;
    wire [7:0] rom_data;

    wire sck_rise = sck_sync_r[1] & ~sck_sync_r[2];
    wire sck_fall = ~sck_sync_r[1] & sck_sync_r[2];
    // Select is gated with ready so that anything clocked in during the hold-off is dropped.
    wire cs_act = ~cs_sync_r[1] & ready_r;
    wire si_bit = si_sync_r[1];
    wire [7:0] shift_nxt = {shift_r[6:0], si_bit};
    wire cnt_done = (cnt_r == 5'h00);
    wire [4:0] cnt_dec = cnt_done ? cnt_r : cnt_r - 5'h01;
    wire is_uid = (shift_nxt == sfdpt_pkg::CMD_UID);
    wire is_sfdp = (shift_nxt == sfdpt_pkg::CMD_SFDP);
    wire is_known = is_uid | is_sfdp;
    wire [7:0] addr_inc = addr_r + 8'h01;
    wire byte_start = (bit_r == 3'h0);
    wire byte_end = (bit_r == 3'h7);
    wire in_data = (state_r == SFDPT_DATA);
    wire out_bit = byte_start ? rom_data[7] : out_byte_r[3'h7 - bit_r];
    wire pu_done = (pu_cnt_r >= 11'(PU_CYCLES - 1));

    sfdpt_rom u_rom (
        .addr_in(addr_r),
        .uid_sel_in(uid_r),
        .data_out(rom_data)
    );

    // Clock, select and data share one synchroniser depth, so they stay aligned.
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            sck_sync_r <= 3'h0;
            cs_sync_r <= 2'h3;
            si_sync_r <= 2'h0;
        end else begin
            sck_sync_r <= {sck_sync_r[1:0], sck_in};
            cs_sync_r <= {cs_sync_r[0], cs_n_in};
            si_sync_r <= {si_sync_r[0], si_in};
        end
    end

    // Power-up access hold-off.
    // The counter is eleven bits wide, so hold-offs beyond 2048 cycles need a wider one.
    always_comb begin
        pu_cnt_nxt = pu_cnt_r;
        ready_nxt = ready_r;
        if (!ready_r) begin
            pu_cnt_nxt = pu_cnt_r + 11'h001;
            ready_nxt = pu_done;
        end
    end

    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            pu_cnt_r <= 11'h000;
            ready_r <= 1'b0;
        end else begin
            pu_cnt_r <= pu_cnt_nxt;
            ready_r <= ready_nxt;
        end
    end

    always_comb begin
        state_nxt = state_r;
        cnt_nxt = cnt_r;
        uid_nxt = uid_r;
        addr_nxt = addr_r;
        if (sck_rise) begin
            cnt_nxt = cnt_dec;
            case (state_r)
                SFDPT_CMD: begin
                    if (cnt_done && is_known) begin
                        state_nxt = SFDPT_ADDR;
                        cnt_nxt = sfdpt_pkg::ADDR_CNT;
                        uid_nxt = is_uid;
                    end else if (cnt_done) begin
                        state_nxt = SFDPT_IGNORE;
                    end
                end
                SFDPT_ADDR: begin
                    if (cnt_done) begin
                        state_nxt = SFDPT_DUMMY;
                        cnt_nxt = sfdpt_pkg::DUMMY_CNT;
                        addr_nxt = shift_nxt;
                    end
                end
                SFDPT_DUMMY: begin
                    if (cnt_done) begin
                        state_nxt = SFDPT_DATA;
                    end
                end
                SFDPT_DATA: begin
                    if (byte_end) begin
                        addr_nxt = addr_inc;
                    end
                end
                // An unknown command is ignored until select rises, so later bits are never decoded.
                SFDPT_IGNORE: begin
                    state_nxt = SFDPT_IGNORE;
                end
                default: state_nxt = SFDPT_CMD;
            endcase
        end
    end

    always_ff @(posedge clk_in) begin
        if (!rst_n_in || !cs_act) begin
            state_r <= SFDPT_CMD;
            cnt_r <= sfdpt_pkg::CMD_CNT;
            shift_r <= 8'h00;
            uid_r <= 1'b0;
            addr_r <= 8'h00;
        end else begin
            state_r <= state_nxt;
            cnt_r <= cnt_nxt;
            shift_r <= sck_rise ? shift_nxt : shift_r;
            uid_r <= uid_nxt;
            addr_r <= addr_nxt;
        end
    end

    // Shift out on falling edges; reads FFh past the end, address wraps after FFh.
    always_comb begin
        so_nxt = so_r;
        oe_n_nxt = oe_n_r;
        bit_nxt = bit_r;
        out_byte_nxt = out_byte_r;
        if (sck_fall && in_data) begin
            oe_n_nxt = 1'b0;
            bit_nxt = bit_r + 3'h1;
            so_nxt = out_bit;
            if (byte_start) begin
                out_byte_nxt = rom_data;
            end
        end
    end

    always_ff @(posedge clk_in) begin
        if (!rst_n_in || !cs_act) begin
            so_r <= 1'b0;
            oe_n_r <= 1'b1;
            bit_r <= 3'h0;
            out_byte_r <= 8'h00;
        end else begin
            so_r <= so_nxt;
            oe_n_r <= oe_n_nxt;
            bit_r <= bit_nxt;
            out_byte_r <= out_byte_nxt;
        end
    end

    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            status_out <= sfdpt_pkg::STATUS_RESET;
        end else begin
            status_out <= sfdpt_pkg::STATUS_RESET;
        end
    end

    assign so_out = so_r;
    assign so_oe_n_out = oe_n_r;
    assign ready_out = ready_r;
endmodule
`default_nettype wire

// ==== tb/sfdpt_properties.sv ====
// Port checks for the identifier and parameter-table reader.
`timescale 1ns/1ps
`default_nettype none
module sfdpt_properties #(
    parameter int PU_CYCLES = sfdpt_pkg::PU_CYCLES
) (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic sck_in,
    input wire logic cs_n_in,
    input wire logic so_out,
    input wire logic so_oe_n_out,
    input wire logic ready_out,
    input wire logic [7:0] status_out
);
    int cnt_r;
    default clocking @(posedge clk_in); endclocking
    default disable iff (!rst_n_in);
    // Saturating count of cycles since reset release.
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) cnt_r <= 0;
        else if (cnt_r < PU_CYCLES + 9) cnt_r <= cnt_r + 1;
    end
    property p_stat; status_out == 8'h00; endproperty
    a_stat: assert property (p_stat) else $error("status");
    property p_early; cnt_r < PU_CYCLES |-> !ready_out; endproperty
    a_early: assert property (p_early) else $error("early ready");
    property p_late; cnt_r > PU_CYCLES + 2 |-> ready_out; endproperty
    a_late: assert property (p_late) else $error("late ready");
    property p_gate; !ready_out |-> so_oe_n_out; endproperty
    a_gate: assert property (p_gate) else $error("drive before ready");
    property p_rel; $rose(cs_n_in) |-> ##[1:4] so_oe_n_out; endproperty
    a_rel: assert property (p_rel) else $error("no release");
    property p_idle; cs_n_in [*5] |-> so_oe_n_out; endproperty
    a_idle: assert property (p_idle) else $error("drive unselected");
    property p_start; $fell(so_oe_n_out) |-> !cs_n_in; endproperty
    a_start: assert property (p_start) else $error("start unselected");
    // Data may only move after a falling serial clock edge.
    property p_hold; sck_in [*4] |-> $stable(so_out); endproperty
    a_hold: assert property (p_hold) else $error("data moved");
    c_drive: cover property ($fell(so_oe_n_out));
    c_ready: cover property ($rose(ready_out));
    c_end: cover property ($rose(cs_n_in));
endmodule
`default_nettype wire

// ==== tb/sfdpt_host.sv ====
// Host controller model driving select, serial clock and command bits.
`timescale 1ns/1ps
`default_nettype none
module sfdpt_host (
    input wire logic clk_in,
    input wire logic miso_in,
    output logic sck_out,
    output logic cs_n_out,
    output logic si_out
);
    initial {sck_out, cs_n_out, si_out} = 3'b010;
    task half();
        repeat (4) @(posedge clk_in);
        #1;
    endtask
    task put(input logic [7:0] b);
        for (int i = 7; i >= 0; i--) begin
            si_out = b[i];
            half();
            sck_out = 1'b1;
            half();
            sck_out = 1'b0;
        end
    endtask
    // command, address, dummy byte, then sixteen bytes
    task xfer(input logic [7:0] cmd, input logic [7:0] adr, output logic [127:0] q);
        cs_n_out = 1'b0;
        half();
        put(cmd);
        put(8'h00);
        put(8'h00);
        put(adr);
        put(8'h00);
        for (int i = 0; i < 128; i++) begin
            half();
            sck_out = 1'b1;
            half();
            q = {q[126:0], miso_in};
            sck_out = 1'b0;
        end
        half();
        cs_n_out = 1'b1;
        half();
    endtask
endmodule
`default_nettype wire

// ==== tb/test_sfdpt_top.sv ====
// Self-checking bench for the identifier and parameter-table reads.
`timescale 1ns/1ps
`default_nettype none
module test_sfdpt_top;
    localparam int PU = 20;
    logic clk_in = 1'b0;
    logic rst_n_in = 1'b0;
    logic oe_seen = 1'b0;
    logic sck, cs_n, si, so, so_oe_n, ready, miso;
    logic [7:0] status;
    logic [127:0] q;
    int bad_count = 0;
    int check_count = 0;
    int cycles = 0;
    always #50 clk_in = ~clk_in;
    // A released line shows the inverse of so_out, which is zero while released, so it always reads one.
    assign miso = so_oe_n ? ~so : so;
    sfdpt_top #(.PU_CYCLES(PU)) DUT (.clk_in(clk_in), .rst_n_in(rst_n_in), .sck_in(sck), .cs_n_in(cs_n),
        .si_in(si), .so_out(so), .so_oe_n_out(so_oe_n), .ready_out(ready), .status_out(status));
    sfdpt_host HOST (.clk_in(clk_in), .miso_in(miso), .sck_out(sck), .cs_n_out(cs_n), .si_out(si));
    always @(posedge clk_in) begin
        cycles <= cycles + 1;
        if (!so_oe_n) oe_seen <= 1'b1;
        if (cycles == 20000) begin
            bad_count = bad_count + 1;
            final_report();
        end
    end
    task check(input logic [127:0] got, input logic [127:0] exp);
        check_count++;
        if (got !== exp) begin
            bad_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task final_report();
        $display("Checks %0d, mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    task t_power();
        check(128'({status, so_oe_n, ready}), 128'h002);
        for (int i = 0; i < PU + 10 && ready !== 1'b1; i++) @(posedge clk_in);
        #1;
        check({127'h0, ready}, 128'h1);
    endtask
    task t_uid();
        HOST.xfer(sfdpt_pkg::CMD_UID, 8'h80, q);
        check(q, {sfdpt_pkg::UID_VALUE, 32'hFFFFFFFF});
    endtask
    // An unknown command 02h must stay silent and alter nothing.
    task t_refuse();
        oe_seen = 1'b0;
        HOST.xfer(8'h02, 8'h80, q);
        check(128'({oe_seen, status}), 128'h000);
    endtask
    task t_table();
        HOST.xfer(sfdpt_pkg::CMD_SFDP, 8'h40, q);
        check({127'h0, q[124]}, 128'h1);
        check({127'h0, q[120]}, 128'h0);
        check(128'(q[95:64]), 128'hFFFF00FF);
        check(128'(q[63:32]), 128'hFFFF44EB);
        check(128'(q[31:0]), 128'h0C200F52);
        HOST.xfer(sfdpt_pkg::CMD_SFDP, 8'h50, q);
        check(128'(q[127:96]), 128'h10D800FF);
    endtask
    initial begin
        repeat (4) @(posedge clk_in);
        #1;
        rst_n_in = 1'b1;
        t_power();
        t_uid();
        t_refuse();
        t_uid();
        t_table();
        final_report();
    end
endmodule
bind sfdpt_top sfdpt_properties #(.PU_CYCLES(PU_CYCLES)) CHK (.clk_in(clk_in), .rst_n_in(rst_n_in),
    .sck_in(sck_in), .cs_n_in(cs_n_in), .so_out(so_out), .so_oe_n_out(so_oe_n_out),
    .ready_out(ready_out), .status_out(status_out));
`default_nettype wire
